/* File: hdl/tigu_pkg.sv */
// Purpose: Shared constants and types of the touch interrupt and pin unit
// Assumes: 25 MHz core clock, APB register access with 32-bit data
// Notes:   Register offsets are word indices; byte address is index times 4
package tigu_pkg;

  // ---------------------------------------------------------------------
  // Register word indices and byte address width
  // ---------------------------------------------------------------------
  localparam logic [9:0] IDX_INT_CFG = 10'h008;
  localparam logic [9:0] IDX_PIN_CFG = 10'h009;
  localparam logic [9:0] IDX_TST_LO = 10'h045;
  localparam logic [9:0] IDX_TST_HI = 10'h046;
  localparam logic [9:0] IDX_SCROLL = 10'h04b;
  localparam logic [9:0] IDX_EVT_STAT = 10'h050;
  localparam logic [9:0] IDX_EVT_CLR = 10'h051;
  localparam logic [9:0] IDX_EVT_EN = 10'h052;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int GPIO_STAT_BIT = 15;
  localparam int EVT_TOUCH = 0;
  localparam int EVT_GPIO = 1;
  localparam int EVT_SLIDER = 2;
  localparam int EVT_N = 3;
  localparam logic [15:0] INT_CFG_RST = 16'h0000;
  localparam logic [15:0] PIN_CFG_RST = 16'h0002;

  // Pin mode field codes
  localparam logic [1:0] PM_OFF = 2'h0;
  localparam logic [1:0] PM_INPUT = 2'h1;
  localparam logic [1:0] PM_OUT_LO = 2'h2;
  localparam logic [1:0] PM_OUT_HI = 2'h3;

  // Trigger type field codes
  localparam logic [2:0] TRG_LOW = 3'h1;
  localparam logic [2:0] TRG_HIGH = 3'h2;
  localparam logic [2:0] TRG_FALL = 3'h5;
  localparam logic [2:0] TRG_RISE = 3'h6;
  localparam logic [2:0] TRG_BOTH = 3'h7;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int IRQ_PULSE_NS = 2000;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] PULSE_LOAD = 8'(IRQ_PULSE_CYC);

  // ---------------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [10:0] rsvd;
    logic guard_off;
    logic slider_en;
    logic open_drain;
    logic read_reset;
    logic act_high;
  } tigu_int_cfg_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] trig;
    logic [1:0] mode;
  } tigu_pin_cfg_t;

endpackage

/* File: hdl/tigu_top.sv */
// Purpose: Interrupt output and general-purpose pin logic of a touch unit
// Assumes: Sensor events arrive as single-cycle pulses on clk_i
// Notes:   Overview of operation follows
`timescale 1ns/1ps
module tigu_top
  import tigu_pkg::*;
#(
  parameter int NSENS = 20
)(
  input wire logic clk_i, // Core clock, 25 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic sens_evt_i, // Sensor touch/untouch event pulse
  input wire logic [4:0] sens_idx_i, // Sensor of the event
  input wire logic sens_touch_i, // 1 touch, 0 untouch
  input wire logic slider_evt_i, // Slider/scroll event pulse
  input wire logic [15:0] scroll_data_i, // Slider location and direction
  input wire logic [NSENS-1:0] excite_i, // Per-sensor excitation
  input wire logic [4:0] conv_sel_i, // Sensor being converted
  output logic guard_o, // Guard drive
  input wire logic gpio_i, // Pin level from pad
  output logic gpio_o, // Pin drive level
  output logic gpio_oe_o, // Pin drive enable
  output logic host_irq_n_o, // Interrupt pin level
  output logic host_irq_oe_o, // Interrupt pin drive enable
  output logic irq_o // Internal event interrupt
);

  if (NSENS < 1 || NSENS > 31)
  begin : g_bad_nsens
    $error("NSENS must be 1 to 31");
  end

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  wire logic [9:0] widx = paddr[ADDR_W-1:2];
  wire logic acc = psel && penable;
  wire logic done = acc && pready;
  wire logic wr_done = done && pwrite;
  wire logic rd_done = done && !pwrite;
  wire logic hit_icfg = (widx == IDX_INT_CFG);
  wire logic hit_pcfg = (widx == IDX_PIN_CFG);
  wire logic hit_tlo = (widx == IDX_TST_LO);
  wire logic hit_thi = (widx == IDX_TST_HI);
  wire logic hit_scr = (widx == IDX_SCROLL);
  wire logic hit_est = (widx == IDX_EVT_STAT);
  wire logic hit_eclr = (widx == IDX_EVT_CLR);
  wire logic hit_een = (widx == IDX_EVT_EN);
  wire logic mapped = hit_icfg | hit_pcfg | hit_tlo | hit_thi | hit_scr |
                      hit_est | hit_eclr | hit_een;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  tigu_int_cfg_t icfg;
  tigu_pin_cfg_t pcfg;
  logic [30:0] tstat, next_tstat;
  logic gpio_stat;
  logic [15:0] scroll;
  logic scroll_pend;
  logic touch_pend;
  logic [7:0] pulse_cnt;
  logic [EVT_N-1:0] evt_stat;
  logic [EVT_N-1:0] evt_en;
  logic rdy;
  logic [31:0] rdata_mux;
  logic g_s1, g_s2, g_s3;

  // ---------------------------------------------------------------------
  // Bus slave: one wait state, data latched from the mux
  // ---------------------------------------------------------------------
  always_comb
  begin
    rdata_mux = 32'h0000_0000;
    if (hit_icfg) rdata_mux = {16'h0000, icfg};
    if (hit_pcfg) rdata_mux = {16'h0000, pcfg};
    if (hit_tlo) rdata_mux = {16'h0000, tstat[15:0]};
    if (hit_thi) rdata_mux = {16'h0000, gpio_stat, tstat[30:16]};
    if (hit_scr) rdata_mux = {16'h0000, scroll};
    if (hit_est) rdata_mux = {29'h0000_0000, evt_stat};
    if (hit_een) rdata_mux = {29'h0000_0000, evt_en};
  end

  assign pready = rdy;
  assign pslverr = rdy && !mapped;

  // Ready and read data capture
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdy <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      rdy <= acc && !rdy;
      if (acc && !rdy && !pwrite)
        prdata <= rdata_mux;
    end
  end

  // Configuration writes
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      icfg <= INT_CFG_RST;
      pcfg <= PIN_CFG_RST;
      evt_en <= '0;
    end
    else if (wr_done && mapped)
    begin
      if (hit_icfg)
        icfg <= {11'h000, pwdata[4:0]};
      if (hit_pcfg)
        pcfg <= {11'h000, pwdata[4:0]};
      if (hit_een)
        evt_en <= pwdata[EVT_N-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Touch status, one bit per sensor
  // ---------------------------------------------------------------------
  for (genvar gi = 0; gi < 31; gi++)
  begin : g_tst
    assign next_tstat[gi] = (gi < NSENS && sens_evt_i &&
                             sens_idx_i == 5'(gi)) ? sens_touch_i :
                            tstat[gi];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      tstat <= '0;
    else
      tstat <= next_tstat;
  end

  // ---------------------------------------------------------------------
  // Pin input: synchroniser and trigger detect
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      g_s1 <= 1'b0;
      g_s2 <= 1'b0;
      g_s3 <= 1'b0;
    end
    else
    begin
      g_s1 <= gpio_i;
      g_s2 <= g_s1;
      g_s3 <= g_s2;
    end
  end

  // Trigger selection; unused codes match nothing
  wire logic in_mode = (pcfg.mode == PM_INPUT);
  wire logic fall = g_s3 && !g_s2;
  wire logic rise = !g_s3 && g_s2;
  wire logic trig_raw = (pcfg.trig == TRG_LOW && !g_s2) ||
                        (pcfg.trig == TRG_HIGH && g_s2) ||
                        (pcfg.trig == TRG_FALL && fall) ||
                        (pcfg.trig == TRG_RISE && rise) ||
                        (pcfg.trig == TRG_BOTH && (fall || rise));
  wire logic trig = in_mode && trig_raw;
  wire logic gpio_evt = trig && !gpio_stat;
  wire logic rd_tlo = rd_done && hit_tlo;
  wire logic rd_thi = rd_done && hit_thi;
  wire logic rd_scr = rd_done && hit_scr;

  // Pin status bit, set wins over read clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      gpio_stat <= 1'b0;
    else if (trig)
      gpio_stat <= 1'b1;
    else if (rd_thi)
      gpio_stat <= 1'b0;
  end

  // Pin drive by mode
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      gpio_oe_o <= 1'b1;
      gpio_o <= 1'b0;
    end
    else
    begin
      gpio_oe_o <= (pcfg.mode == PM_OUT_LO) || (pcfg.mode == PM_OUT_HI);
      gpio_o <= (pcfg.mode == PM_OUT_HI);
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt sources and hold flags
  // ---------------------------------------------------------------------
  wire logic any_evt = sens_evt_i || gpio_evt || slider_evt_i;

  // Touch pending until low status read; scroll pending until scroll read
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      touch_pend <= 1'b0;
      scroll_pend <= 1'b0;
      scroll <= 16'h0000;
    end
    else
    begin
      if (sens_evt_i)
        touch_pend <= 1'b1;
      else if (rd_tlo)
        touch_pend <= 1'b0;
      if (slider_evt_i)
      begin
        scroll_pend <= 1'b1;
        scroll <= scroll_data_i;
      end
      else if (rd_scr)
        scroll_pend <= 1'b0;
    end
  end

  // Fixed-duration pulse counter, retriggered by each event
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      pulse_cnt <= 8'h00;
    else if (any_evt)
      pulse_cnt <= PULSE_LOAD;
    else if (pulse_cnt != 8'h00)
      pulse_cnt <= pulse_cnt - 8'h01;
  end

  // Asserted state by mode
  wire logic hold_slider = icfg.slider_en && scroll_pend;
  wire logic rr_active = touch_pend || gpio_stat;
  wire logic fx_active = (pulse_cnt != 8'h00);
  wire logic irq_active = (icfg.read_reset ? rr_active : fx_active) ||
                          hold_slider;

  // Output pin level and drive enable
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      host_irq_n_o <= 1'b1;
      host_irq_oe_o <= 1'b1;
    end
    else
    begin
      host_irq_n_o <= icfg.act_high ? irq_active : !irq_active;
      host_irq_oe_o <= !icfg.open_drain || irq_active;
    end
  end

  // Guard drive follows the converting sensor
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      guard_o <= 1'b0;
    else if (icfg.guard_off || conv_sel_i >= 5'(NSENS))
      guard_o <= 1'b0;
    else
      guard_o <= excite_i[conv_sel_i];
  end

  // ---------------------------------------------------------------------
  // Event status, clear and enable for the internal interrupt
  // ---------------------------------------------------------------------
  wire logic [EVT_N-1:0] evt_set = {slider_evt_i, gpio_evt, sens_evt_i};
  wire logic [EVT_N-1:0] evt_clr = (wr_done && hit_eclr) ?
                                   pwdata[EVT_N-1:0] : '0;

  // Set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      evt_stat <= '0;
    else
      evt_stat <= evt_set | (evt_stat & ~evt_clr);
  end

  assign irq_o = |(evt_stat & evt_en);

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_pin_reset_low: assert property (
    $rose(rstn_i) |-> gpio_oe_o && !gpio_o)
    else $error("pin not low output after reset");
  chk_pin_mode_drive: assert property (
    (pcfg.mode == PM_OUT_HI) |=> gpio_oe_o && gpio_o)
    else $error("pin not high in high mode");
  chk_input_release: assert property (
    in_mode && $stable(pcfg) |=> !gpio_oe_o)
    else $error("pin driven in input mode");
  chk_fixed_pulse: assert property (
    !icfg.read_reset && !hold_slider && !icfg.act_high && sens_evt_i
    ##1 (!any_evt && !icfg.read_reset && !hold_slider)[*8]
    |-> !host_irq_n_o)
    else $error("pulse shorter than expected");
  chk_pulse_ends: assert property (
    (pulse_cnt == 8'h01) && !any_evt |=> !fx_active)
    else $error("pulse counter did not end");
  chk_touch_bit: assert property (
    sens_evt_i && sens_idx_i == 5'h00 |=> tstat[0] == $past(sens_touch_i))
    else $error("touch bit not updated");
  chk_rr_hold: assert property (
    icfg.read_reset && touch_pend && !rd_tlo |=> touch_pend)
    else $error("read-reset hold lost early");
  chk_high_read_clr: assert property (
    rd_thi && !trig |=> !gpio_stat)
    else $error("pin status not cleared by read");
  chk_trig_set: assert property (
    trig |=> gpio_stat)
    else $error("pin status not set on trigger");
  chk_sync_delay: assert property (
    in_mode && pcfg.trig == TRG_RISE && rise |-> $past(g_s1, 1))
    else $error("edge seen before synchroniser");
  chk_slider_hold: assert property (
    hold_slider && !rd_scr |=> irq_active)
    else $error("slider hold released early");

  cov_touch_pulse: cover property (
    sens_evt_i && !icfg.read_reset ##1 fx_active[*8]);
  cov_rr_cycle: cover property (
    icfg.read_reset && sens_evt_i ##[1:200] rd_tlo);
  cov_gpio_edge: cover property (in_mode && gpio_evt);
  cov_open_drain: cover property (icfg.open_drain && irq_active);

endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the touch interrupt and pin unit
// Assumes: Default 20 sensors, 25 MHz clock, fixed seed
// Notes:   Expectations come from bench functions and shadow state
`timescale 1ns/1ps
module tb
  import tigu_pkg::*;
;
  logic clk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q, lo, hi;
  logic sens_evt_i, sens_touch_i, slider_evt_i, gpio_ext, e;
  logic [4:0] sens_idx_i, conv_sel_i;
  logic [15:0] scroll_data_i;
  logic [19:0] excite_i;
  logic guard_o, gpio_o, gpio_oe_o, host_irq_n_o, host_irq_oe_o, irq_o;
  logic [30:0] exp_st;
  int bad_count, num_checks, n, i;
  bit a;
  // Pad level: the unit wins while it drives the pin
  wire gpio_pad = gpio_oe_o ? gpio_o : gpio_ext;

  tigu_top uut (.clk_i, .rstn_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sens_evt_i, .sens_idx_i,
    .sens_touch_i, .slider_evt_i, .scroll_data_i, .excite_i,
    .conv_sel_i, .guard_o, .gpio_i(gpio_pad), .gpio_o, .gpio_oe_o,
    .host_irq_n_o, .host_irq_oe_o, .irq_o);
  tigu_host h (.clk_i, .prdata, .pready, .pslverr,
    .irq_n_i(host_irq_n_o), .psel, .penable, .pwrite, .paddr, .pwdata);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Clock, 40 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Sensor event pulse, tracked in the shadow status
  task automatic ev(input int s, input bit t);
    @(posedge clk_i);
    sens_evt_i <= 1'b1;
    sens_idx_i <= 5'(s);
    sens_touch_i <= t;
    @(posedge clk_i);
    sens_evt_i <= 1'b0;
    exp_st[s] = t;
  endtask

  // Count cycles with the interrupt pin low
  task automatic lowcnt(output int k);
    k = 0;
    repeat (80)
    begin
      @(posedge clk_i);
      if (host_irq_n_o === 1'b0) k++;
    end
  endtask

  // Level and edge trigger expectations
  function automatic bit lv(logic [2:0] c, bit x);
    return (c === TRG_LOW && !x) || (c === TRG_HIGH && x);
  endfunction

  function automatic bit eg(logic [2:0] c, bit x);
    return c === TRG_BOTH || (c === TRG_FALL && x)
      || (c === TRG_RISE && !x);
  endfunction

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    cyc(20000);
    bad_count++;
    summarize();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h9b50da5b));
    {rstn_i, sens_evt_i, sens_touch_i, slider_evt_i, gpio_ext} = '0;
    {sens_idx_i, conv_sel_i, scroll_data_i, excite_i} = '0;
    exp_st = '0;
    cyc(8);
    rstn_i <= 1'b1;
    cyc(2);
    chk(32'({gpio_oe_o, gpio_o}), 32'h2);
    chk(32'({host_irq_n_o, host_irq_oe_o, irq_o}), 32'h6);
    h.rd(IDX_INT_CFG, q);
    chk(q, 32'(INT_CFG_RST));
    h.rd(IDX_PIN_CFG, q);
    chk(q, 32'(PIN_CFG_RST));
    h.xfer(1'b0, 10'h3ff, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    h.wr(IDX_TST_LO, 32'hffff);
    h.rd(IDX_TST_LO, q);
    chk(q, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      h.wr(IDX_PIN_CFG, 32'(m));
      cyc(3);
      chk(32'({gpio_oe_o, gpio_o}), 32'({m[1], m == 3}));
    end
    repeat (4)
    begin
      excite_i <= 20'($urandom);
      conv_sel_i <= 5'($urandom % 20);
      cyc(3);
      chk(32'(guard_o), 32'(excite_i[conv_sel_i]));
    end
    excite_i <= '1;
    h.wr(IDX_INT_CFG, 32'h10);
    cyc(3);
    chk(32'(guard_o), 32'h0);
    h.wr(IDX_INT_CFG, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      i = (k == 0) ? 19 : (k == 1) ? 0 : int'($urandom % 20);
      for (int t = 1; t >= 0; t--)
      begin
        ev(i, t[0]);
        lowcnt(n);
        chk(32'(n), 32'(IRQ_PULSE_CYC));
        h.rd(IDX_TST_LO, q);
        chk(q, 32'(exp_st[15:0]));
        h.rd(IDX_TST_HI, q);
        chk(q & 32'h7fff, 32'(exp_st[30:16]));
      end
    end
    h.rd(IDX_EVT_STAT, q);
    chk(q, 32'h1);
    h.wr(IDX_EVT_EN, 32'h1);
    cyc(2);
    chk(32'(irq_o), 32'h1);
    h.wr(IDX_EVT_EN, 32'h0);
    cyc(2);
    chk(32'(irq_o), 32'h0);
    h.wr(IDX_EVT_CLR, 32'h7);
    h.rd(IDX_EVT_STAT, q);
    chk(q, 32'h0);
    h.wr(IDX_INT_CFG, 32'h5);
    cyc(3);
    chk(32'(host_irq_oe_o), 32'h0);
    ev(3, 1'b1);
    cyc(3);
    chk(32'({host_irq_n_o, host_irq_oe_o}), 32'h3);
    cyc(60);
    h.wr(IDX_INT_CFG, 32'h2);
    for (int t = 1; t >= 0; t--)
    begin
      ev(5, t[0]);
      cyc(60);
      chk(32'(host_irq_n_o), 32'h0);
      h.svc(3 * t, lo, hi);
      cyc(4);
      chk(32'(host_irq_n_o), 32'h1);
      chk(lo, 32'(exp_st[15:0]));
    end
    h.wr(IDX_INT_CFG, 32'h8);
    scroll_data_i <= 16'($urandom);
    slider_evt_i <= 1'b1;
    cyc(1);
    slider_evt_i <= 1'b0;
    cyc(60);
    chk(32'(host_irq_n_o), 32'h0);
    h.rd(IDX_SCROLL, q);
    chk(q, 32'(scroll_data_i));
    cyc(4);
    chk(32'(host_irq_n_o), 32'h1);
    h.wr(IDX_INT_CFG, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      h.wr(IDX_PIN_CFG, 32'({3'(c), PM_INPUT}));
      a = 1'($urandom);
      gpio_ext <= a;
      cyc(8);
      h.rd(IDX_TST_HI, q);
      gpio_ext <= !a;
      cyc(8);
      h.rd(IDX_TST_HI, q);
      chk(32'(q[15]), 32'(lv(3'(c), a) || lv(3'(c), !a)
        || eg(3'(c), a)));
      h.rd(IDX_TST_HI, q);
      chk(32'(q[15]), 32'(lv(3'(c), !a)));
    end
    h.wr(IDX_PIN_CFG, 32'({TRG_BOTH, PM_OFF}));
    h.rd(IDX_TST_HI, q);
    gpio_ext <= !gpio_ext;
    cyc(8);
    h.rd(IDX_TST_HI, q);
    chk(32'(q[15]), 32'h0);
    summarize();
  end
endmodule

/* File: sim/tigu_host.sv */
// Purpose: Host model, APB master that reads interrupt status
// Assumes: Slave answers on pready, no cycle count assumed
// Notes:   Each transfer opens one clock after the last one ends
`timescale 1ns/1ps
module tigu_host
  import tigu_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic irq_n_i, // Interrupt pin level
  output logic psel, // APB select
  output logic penable, // APB enable
  output logic pwrite, // APB direction
  output logic [ADDR_W-1:0] paddr, // APB byte address
  output logic [31:0] pwdata // APB write data
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // Setup, then access held until pready is sampled high
  task automatic xfer(input bit w, input logic [9:0] idx,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, idx, d, q, e);
  endtask

  // Register read
  task automatic rd(input logic [9:0] idx, output logic [31:0] q);
    logic e;
    xfer(1'b0, idx, 32'h0, q, e);
  endtask

  // Wait for the interrupt, then read both status words after lag
  task automatic svc(input int lag, output logic [31:0] lo, hi);
    while (irq_n_i !== 1'b0)
      @(posedge clk_i);
    repeat (lag) @(posedge clk_i);
    rd(IDX_TST_LO, lo);
    rd(IDX_TST_HI, hi);
  endtask
endmodule
